//--- otfm_output_mux.sv
// output terminal function selector with register port
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module otfm_output_mux #(
   parameter int PLC_PULSE_CYCLES = otfm_pkg::PLC_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire otfm_pkg::otfm_bus_req_t bus_req,
   output logic [otfm_pkg::DATA_W-1:0] bus_rdata,
   input wire otfm_pkg::otfm_status_t drive_status,
   output logic pulse_switch_output,
   output logic board_relay,
   output logic ext_relay,
   output logic collector_output_one
);
   import otfm_pkg::*;

   // assertions below share one clock and one reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   logic [7:0] mode_ff;
   logic [7:0] pulse_div_ff;
   logic [7:0] sel_ff [NUM_TERM];
   logic term_ff [NUM_TERM];
   logic [19:0] pcnt_ff;
   logic wave_ff;
   logic pso_ff;
   logic [31:0] plc_cnt_ff;
   logic plc_pulse_ff;
   logic [7:0] rdata_ff;
   logic [7:0] rd_val;
   logic [19:0] half_lim;

   // ----------------------------------------------------------
   // status to level decode
   // ----------------------------------------------------------
   // one decoder serves all terminals, so codes cannot drift apart
   function automatic logic fn_level(
      input logic [7:0] sel,
      input otfm_status_t s,
      input logic plc
   );
      logic lvl;
      lvl = 1'b0;
      case (sel)
         FN_NONE: lvl = 1'b0;
         FN_RUNNING: lvl = s.running;
         FN_FAULT: lvl = s.fault_stop;
         FN_FREQ_LEVEL_DETECT_ONE: lvl = s.freq_level_detect_one;
         FN_FREQ_REACHED: lvl = s.freq_reached;
         FN_ZERO_RUN: lvl = s.running & s.freq_zero;
         FN_MOTOR_OVLD: lvl = s.motor_ovld_warn;
         FN_DRIVE_OVLD: lvl = s.drive_ovld_warn;
         FN_SET_COUNT: lvl = s.set_count_hit;
         FN_DESIG_COUNT: lvl = s.desig_count_hit;
         FN_LENGTH: lvl = s.length_hit;
         FN_PLC_DONE: lvl = plc;
         default: lvl = 1'b0;
      endcase
      return lvl;
   endfunction : fn_level

   // ----------------------------------------------------------
   // mode and pulse rate registers
   // ----------------------------------------------------------
   // mode select
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_ff <= MODE_RST;
      end else if (bus_req.wr && bus_req.addr == REG_MODE &&
                   bus_req.wdata <= MODE_SWITCH) begin
         mode_ff <= bus_req.wdata;
      end
   end

   // divider 0 parks the pulse output low
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pulse_div_ff <= PULSE_DIV_RST;
      end else if (bus_req.wr && bus_req.addr == REG_PULSE_DIV) begin
         pulse_div_ff <= bus_req.wdata;
      end
   end

   // ----------------------------------------------------------
   // per-terminal selectors and outputs
   // ----------------------------------------------------------
   // independent selectors
   for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
      logic sel_hit;
      assign sel_hit = bus_req.wr &&
                       bus_req.addr == 4'(REG_SW_FN + 4'(i));

      // range and reset
      // out-of-range writes are dropped, old function stays
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            sel_ff[i] <= SEL_RST[i];
         end else if (sel_hit && bus_req.wdata <= SEL_MAX[i]) begin
            sel_ff[i] <= bus_req.wdata;
         end
      end

      always_ff @(posedge sys_clk) begin
         if (rst) begin
            term_ff[i] <= 1'b0;
         end else begin
            term_ff[i] <= fn_level(sel_ff[i], drive_status,
                                   plc_pulse_ff);
         end
      end

      property p_sel_range;
         (sel_hit && bus_req.wdata > SEL_MAX[i]) |=> $stable(sel_ff[i]);
      endproperty
      a_sel_range: assert property (p_sel_range)
         else $error("selector took an out-of-range value");

      property p_none_off;
         (sel_ff[i] == FN_NONE) |=> !term_ff[i];
      endproperty
      a_none_off: assert property (p_none_off)
         else $error("terminal on with no function selected");

      property p_run_follow;
         (sel_ff[i] == FN_RUNNING) |=>
            (term_ff[i] == $past(drive_status.running));
      endproperty
      a_run_follow: assert property (p_run_follow)
         else $error("running function not followed");

      property p_zero_run;
         (sel_ff[i] == FN_ZERO_RUN && !drive_status.running) |=>
            !term_ff[i];
      endproperty
      a_zero_run: assert property (p_zero_run)
         else $error("zero speed output on while stopped");

      property p_rsvd_off;
         (sel_ff[i] > FN_PLC_DONE) |=> !term_ff[i];
      endproperty
      a_rsvd_off: assert property (p_rsvd_off)
         else $error("reserved function drove a terminal");

      property p_fault_follow;
         (sel_ff[i] == FN_FAULT) |=>
            (term_ff[i] == $past(drive_status.fault_stop));
      endproperty
      a_fault_follow: assert property (p_fault_follow)
         else $error("fault function not followed");

      property p_level_follow;
         (sel_ff[i] == FN_FREQ_LEVEL_DETECT_ONE) |=>
            (term_ff[i] == $past(drive_status.freq_level_detect_one));
      endproperty
      a_level_follow: assert property (p_level_follow)
         else $error("level detector function not followed");

      property p_count_follow;
         (sel_ff[i] == FN_SET_COUNT) |=>
            (term_ff[i] == $past(drive_status.set_count_hit));
      endproperty
      a_count_follow: assert property (p_count_follow)
         else $error("set count function not followed");

      // selector write then output update, two steps
      sequence s_wr_fault;
         sel_hit && bus_req.wdata == FN_FAULT;
      endsequence
      sequence s_fault_shown;
         ##2 (term_ff[i] == $past(drive_status.fault_stop));
      endsequence
      property p_wr_follow;
         s_wr_fault |-> s_fault_shown;
      endproperty
      a_wr_follow: assert property (p_wr_follow)
         else $error("terminal late after selector write");
   end

   // ----------------------------------------------------------
   // pulse generator
   // ----------------------------------------------------------
   // half period is a whole multiple of the 100 kHz half period
   assign half_lim = 20'(PULSE_HALF_CYC) * 20'(pulse_div_ff);

   // rate limited pulse
   // >= compare catches a divider lowered mid-period
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pcnt_ff <= 20'h00000;
         wave_ff <= 1'b0;
      end else if (pulse_div_ff == 8'h00) begin
         pcnt_ff <= 20'h00000;
         wave_ff <= 1'b0;
      end else if (pcnt_ff >= half_lim - 20'h00001) begin
         pcnt_ff <= 20'h00000;
         wave_ff <= ~wave_ff;
      end else begin
         pcnt_ff <= pcnt_ff + 20'h00001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pso_ff <= 1'b0;
      end else if (mode_ff == MODE_PULSE) begin
         pso_ff <= wave_ff;
      end else begin
         pso_ff <= term_ff[TERM_SW];
      end
   end

   // ----------------------------------------------------------
   // sequencer-complete pulse stretcher
   // ----------------------------------------------------------
   // 250 ms pulse
   // a new completion restarts the full width
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         plc_cnt_ff <= 32'h00000000;
         plc_pulse_ff <= 1'b0;
      end else if (drive_status.plc_cycle_done) begin
         plc_cnt_ff <= 32'(PLC_PULSE_CYCLES - 1);
         plc_pulse_ff <= 1'b1;
      end else if (plc_cnt_ff != 32'h00000000) begin
         plc_cnt_ff <= plc_cnt_ff - 32'h00000001;
      end else begin
         plc_pulse_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------
   // read port
   // ----------------------------------------------------------
   // read mux, reserved and unmapped offsets give zero
   always_comb begin
      rd_val = 8'h00;
      case (bus_req.addr)
         REG_MODE: rd_val = mode_ff;
         REG_PULSE_DIV: rd_val = pulse_div_ff;
         REG_TERM_STAT: rd_val = {3'h0, pso_ff, term_ff[3],
                                  term_ff[2], term_ff[1], term_ff[0]};
         default: begin
            if (bus_req.addr >= REG_SW_FN &&
                bus_req.addr <= REG_COL_FN) begin
               rd_val = sel_ff[2'(bus_req.addr - REG_SW_FN)];
            end
         end
      endcase
   end

   // data valid only in the cycle after the read strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (bus_req.rd) begin
         rdata_ff <= rd_val;
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign bus_rdata = rdata_ff;
   assign pulse_switch_output = pso_ff;
   assign board_relay = term_ff[1];
   assign ext_relay = term_ff[2];
   assign collector_output_one = term_ff[3];

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   localparam int HALF_MIN = PULSE_HALF_CYC;

   // cycles since the wave last moved, saturating
   logic wave_q_ff;
   logic [15:0] since_ff;
   logic wave_tog;
   assign wave_tog = wave_ff ^ wave_q_ff;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wave_q_ff <= 1'b0;
         since_ff <= 16'h0000;
      end else begin
         wave_q_ff <= wave_ff;
         if (wave_tog) begin
            since_ff <= 16'h0000;
         end else if (since_ff != 16'hffff) begin
            since_ff <= since_ff + 16'h0001;
         end
      end
   end

   // a stop by divider 0 may cut the last half short
   // since_ff seen at a toggle is the spacing from the last one, less one
   property p_pulse_rate;
      (wave_tog && $past(pulse_div_ff) != 8'h00) |->
         (since_ff >= 16'(HALF_MIN - 1));
   endproperty
   a_pulse_rate: assert property (p_pulse_rate)
      else $error("pulse half period below the 100 kHz limit");

   property p_mode_out;
      (mode_ff == MODE_PULSE) |=> (pulse_switch_output == $past(wave_ff));
   endproperty
   a_mode_out: assert property (p_mode_out)
      else $error("pulse mode not routed to the shared pin");

   property p_switch_out;
      (mode_ff == MODE_SWITCH) |=>
         (pulse_switch_output == $past(term_ff[TERM_SW]));
   endproperty
   a_switch_out: assert property (p_switch_out)
      else $error("switch mode not routed to the shared pin");

   sequence s_plc_event;
      drive_status.plc_cycle_done;
   endsequence
   sequence s_plc_held;
      ##1 plc_pulse_ff [*8];
   endsequence
   property p_plc_pulse;
      s_plc_event |-> s_plc_held;
   endproperty
   a_plc_pulse: assert property (p_plc_pulse)
      else $error("sequencer pulse shorter than expected");

   property p_rd_zero;
      !bus_req.rd |=> (bus_rdata == 8'h00);
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("read data outside the answer cycle");

endmodule : otfm_output_mux

//--- otfm_pkg.sv
// constants and types for the output terminal function selector
package otfm_pkg;

   // ----------------------------------------------------------
   // timing
   // ----------------------------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int PULSE_MAX_KHZ = 100;
   // least pulse period in clocks, rounded up
   localparam int PULSE_MIN_CYC =
      (CLK_MHZ * 1000 + PULSE_MAX_KHZ - 1) / PULSE_MAX_KHZ;
   localparam int PULSE_HALF_CYC = (PULSE_MIN_CYC + 1) / 2;
   localparam int PLC_PULSE_MS = 250;
   localparam int PLC_PULSE_CYC = PLC_PULSE_MS * CLK_MHZ * 1000;

   // ----------------------------------------------------------
   // register map
   // ----------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] REG_MODE = 4'h0;
   localparam logic [3:0] REG_SW_FN = 4'h1;
   localparam logic [3:0] REG_BRD_FN = 4'h2;
   localparam logic [3:0] REG_EXT_FN = 4'h3;
   localparam logic [3:0] REG_COL_FN = 4'h4;
   localparam logic [3:0] REG_RSVD = 4'h5;
   localparam logic [3:0] REG_PULSE_DIV = 4'h6;
   localparam logic [3:0] REG_TERM_STAT = 4'h7;

   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] MODE_PULSE = 8'h00;
   localparam logic [7:0] MODE_SWITCH = 8'h01;
   localparam logic [7:0] PULSE_DIV_RST = 8'h00;

   // terminals steered by a selector, in register order
   localparam int NUM_TERM = 4;
   localparam int TERM_SW = 0;
   localparam logic [7:0] SEL_RST [NUM_TERM] =
      '{8'h00, 8'h02, 8'h00, 8'h01};
   localparam logic [7:0] SEL_MAX [NUM_TERM] =
      '{8'h28, 8'h28, 8'h28, 8'h29};

   // ----------------------------------------------------------
   // function codes
   // ----------------------------------------------------------
   localparam logic [7:0] FN_NONE = 8'h00;
   localparam logic [7:0] FN_RUNNING = 8'h01;
   localparam logic [7:0] FN_FAULT = 8'h02;
   localparam logic [7:0] FN_FREQ_LEVEL_DETECT_ONE = 8'h03;
   localparam logic [7:0] FN_FREQ_REACHED = 8'h04;
   localparam logic [7:0] FN_ZERO_RUN = 8'h05;
   localparam logic [7:0] FN_MOTOR_OVLD = 8'h06;
   localparam logic [7:0] FN_DRIVE_OVLD = 8'h07;
   localparam logic [7:0] FN_SET_COUNT = 8'h08;
   localparam logic [7:0] FN_DESIG_COUNT = 8'h09;
   localparam logic [7:0] FN_LENGTH = 8'h0a;
   localparam logic [7:0] FN_PLC_DONE = 8'h0b;

   // ----------------------------------------------------------
   // carriers
   // ----------------------------------------------------------
   typedef struct packed {
      logic running;
      logic freq_zero;
      logic fault_stop;
      logic freq_level_detect_one;
      logic freq_reached;
      logic motor_ovld_warn;
      logic drive_ovld_warn;
      logic set_count_hit;
      logic desig_count_hit;
      logic length_hit;
      logic plc_cycle_done;
   } otfm_status_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } otfm_bus_req_t;

endpackage : otfm_pkg

//--- otfm_terminal_load.sv
// load model on the output terminals, timing the pulse pin
`timescale 1ns/100ps
module otfm_terminal_load (
   input wire logic sys_clk,
   input wire logic clear_stats,
   input wire logic pulse_switch_output,
   output int rise_count,
   output int min_gap
);
   // ----------------------------------------------------------
   // pulse spacing
   // ----------------------------------------------------------
   logic last_ff;
   int gap_ff;
   // a gap runs from one rising edge to the next; the first one is skipped
   // because it has no start
   always_ff @(posedge sys_clk) begin
      last_ff <= pulse_switch_output;
      gap_ff <= gap_ff + 1;
      if (clear_stats) begin
         rise_count <= 0;
         min_gap <= 1 << 30;
      end else if (pulse_switch_output && !last_ff) begin
         rise_count <= rise_count + 1;
         gap_ff <= 1;
         if (rise_count > 0 && gap_ff < min_gap) begin
            min_gap <= gap_ff;
         end
      end
   end
endmodule : otfm_terminal_load

//--- otfm_output_mux_bench.sv
// self-checking bench for the output terminal function selector
`timescale 1ns/100ps
module otfm_output_mux_bench;
   import otfm_pkg::*;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   localparam int PLC = 20;
   // status bits that must all be high for each function code 0..10
   localparam logic [10:0] CAUSE [11] = '{11'h000, 11'h400, 11'h100,
      11'h080, 11'h040, 11'h600, 11'h020, 11'h010, 11'h008, 11'h004,
      11'h002};
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clear_stats = 1'b1;
   otfm_bus_req_t req = '0;
   otfm_status_t status = '0;
   logic [7:0] bus_rdata;
   logic pso, brd, ext, col;
   int rise_count, min_gap;
   int failures = 0;
   int n_compared = 0;

   always #2 sys_clk = ~sys_clk;

   otfm_output_mux #(.PLC_PULSE_CYCLES(PLC)) dut_u (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus_req(req),
      .bus_rdata(bus_rdata),
      .drive_status(status),
      .pulse_switch_output(pso),
      .board_relay(brd),
      .ext_relay(ext),
      .collector_output_one(col)
   );

   otfm_terminal_load load_u (
      .sys_clk(sys_clk),
      .clear_stats(clear_stats),
      .pulse_switch_output(pso),
      .rise_count(rise_count),
      .min_gap(min_gap)
   );

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1;
      chk($sformatf("reg %0d", a), exp, bus_rdata);
   endtask : rd

   task automatic set_sel(input logic [7:0] f);
      for (int t = 1; t <= 4; t++) begin
         wr(t[3:0], f);
      end
   endtask : set_sel

   // applies a status word, lets it settle, then judges all terminals
   task automatic settle(input logic [10:0] st, input logic [3:0] exp);
      @(posedge sys_clk);
      status <= otfm_status_t'(st);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("terminals col ext brd sw", {4'h0, exp}, {4'h0, col, ext, brd, pso});
   endtask : settle

   function automatic logic on_for(input int f, input logic [10:0] st);
      logic [10:0] m;
      m = (f <= 10) ? CAUSE[f] : 11'h000;
      return (m != 11'h000) && ((st & m) == m);
   endfunction : on_for

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_reset_values();
      rd(REG_MODE, 8'h00);
      rd(REG_SW_FN, 8'h00);
      rd(REG_BRD_FN, 8'h02);
      rd(REG_EXT_FN, 8'h00);
      rd(REG_COL_FN, 8'h01);
      rd(REG_RSVD, 8'h00);
      rd(4'h9, 8'h00);
   endtask : t_reset_values

   // writes just past the sw, ext, col and mode ranges are dropped, the top value is kept
   task automatic t_ranges();
      wr(REG_SW_FN, 8'h29);
      rd(REG_SW_FN, 8'h00);
      wr(REG_BRD_FN, 8'h28);
      rd(REG_BRD_FN, 8'h28);
      wr(REG_EXT_FN, 8'h29);
      rd(REG_EXT_FN, 8'h00);
      wr(REG_COL_FN, 8'h29);
      wr(REG_COL_FN, 8'h2a);
      rd(REG_COL_FN, 8'h29);
      wr(REG_MODE, 8'h02);
      rd(REG_MODE, 8'h00);
   endtask : t_ranges

   // codes 0 to 12 and 40 on all terminals: cause alone, everything but the cause
   task automatic t_fn_table();
      logic [10:0] c;
      logic [10:0] n;
      int f;
      wr(REG_MODE, MODE_SWITCH);
      for (int i = 0; i < 14; i++) begin
         f = (i == 13) ? 40 : i;
         c = (f <= 10) ? CAUSE[f] : 11'h7fe;
         n = ~c & 11'h7fe;
         set_sel(f[7:0]);
         settle(c, {4{on_for(f, c)}});
         settle(n, {4{on_for(f, n)}});
         // zero frequency while stopped must leave code 5 off
         settle(11'h200, {4{on_for(f, 11'h200)}});
         settle(11'h400, {4{on_for(f, 11'h400)}});
      end
   endtask : t_fn_table

   task automatic t_independent();
      wr(REG_SW_FN, FN_RUNNING);
      wr(REG_BRD_FN, FN_FAULT);
      wr(REG_EXT_FN, FN_FREQ_LEVEL_DETECT_ONE);
      wr(REG_COL_FN, FN_FREQ_REACHED);
      settle(11'h000, 4'h0);
      @(posedge sys_clk);
      status <= otfm_status_t'(11'h180);
      #1;
      chk("registered outs", 8'h00, {4'h0, col, ext, brd, pso});
      settle(11'h180, 4'b0110);
      rd(REG_TERM_STAT, 8'h06);
   endtask : t_independent

   // one sequencer pulse stretches to a fixed width on every terminal
   task automatic t_plc();
      set_sel(FN_PLC_DONE);
      settle(11'h000, 4'h0);
      @(posedge sys_clk);
      status.plc_cycle_done <= 1'b1;
      @(posedge sys_clk);
      status.plc_cycle_done <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("pulse start", 8'h0f, {4'h0, col, ext, brd, pso});
      repeat (PLC - 5) @(posedge sys_clk);
      #1;
      chk("pulse hold", 8'h0f, {4'h0, col, ext, brd, pso});
      // relays drop a clock before the shared pin, which has one more stage
      repeat (3) @(posedge sys_clk);
      #1;
      chk("pulse end", 8'h01, {4'h0, col, ext, brd, pso});
      @(posedge sys_clk);
      #1;
      chk("pulse pin end", 8'h00, {4'h0, col, ext, brd, pso});
   endtask : t_plc

   // fastest divider must still keep the pulse pin at or under 100 kHz
   task automatic t_pulse();
      wr(REG_MODE, MODE_PULSE);
      wr(REG_PULSE_DIV, 8'h01);
      rd(REG_MODE, 8'h00);
      rd(REG_PULSE_DIV, 8'h01);
      @(posedge sys_clk);
      clear_stats <= 1'b0;
      repeat (6 * PULSE_HALF_CYC) @(posedge sys_clk);
      #1;
      chk("pulse edges", 8'h01, {7'h0, rise_count >= 2});
      chk("pulse gap", 8'h01, {7'h0, min_gap >= PULSE_MIN_CYC});
      wr(REG_PULSE_DIV, 8'h00);
      wr(REG_SW_FN, FN_RUNNING);
      settle(11'h400, 4'h0);
   endtask : t_pulse

   // a reset in mid-run clears the terminals and restores every selector
   task automatic t_mid_reset();
      wr(REG_MODE, MODE_SWITCH);
      wr(REG_BRD_FN, FN_RUNNING);
      settle(11'h400, 4'h3);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("outputs in reset", 8'h00, {4'h0, col, ext, brd, pso});
      @(posedge sys_clk);
      rst <= 1'b0;
      t_reset_values();
   endtask : t_mid_reset

   // ----------------------------------------------------------
   // run control
   // ----------------------------------------------------------
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // bound set well above the roughly 8000 cycles the scenarios need
   initial begin
      repeat (40000) @(posedge sys_clk);
      failures++;
      tally_and_finish();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset_values();
      t_ranges();
      t_fn_table();
      t_independent();
      t_plc();
      t_pulse();
      t_mid_reset();
      tally_and_finish();
   end
endmodule : otfm_output_mux_bench
